// ---- logic/tapc_defines.vh ----
// constants for the auxiliary pin configuration block
// assumes a 50 MHz system clock and an axi4-lite register port
//
// How it works
// - pin a field bits 1:0: 00 input, 01 output, 10 reserved, 11 clock-failure
// - clock-failure mode: drive zero as active master, else read failure input
// - pins b to e: 00 input, 01 drives that pin's value bit
// - pin b code 10: message channel line, rx to pin d, tx from c
// - pin b code 11: network reference clock input for time stamp recovery
// - pin c code 10: transmit data input for message channel
// - pin c code 11: time stamp valid output while pin d carries a bit
// - pin d code 10: outputs received message channel data
// - pin d code 11: outputs residual time stamp data bits
// - pin e code 10: message channel clock output; code 11 reserved
// - bits 11 to 15 are pin a..e levels, used only in output code
// - status register bits 11 to 15 show present pin a..e levels
`ifndef TAPC_DEFINES_VH
`define TAPC_DEFINES_VH

// register map, byte addresses
`define TAPC_ADDR_W       16
`define TAPC_CFG_ADDR     16'h6004
`define TAPC_STAT_ADDR    16'h6008
`define TAPC_CFG_RST      16'h0000

// field positions in the configuration word
`define TAPC_SEL_A_LSB    0
`define TAPC_SEL_B_LSB    2
`define TAPC_SEL_C_LSB    4
`define TAPC_SEL_D_LSB    6
`define TAPC_SEL_E_LSB    8
`define TAPC_RSVD_BIT     10
`define TAPC_VAL_LSB      11
`define TAPC_NPINS        5

// role codes
`define TAPC_ROLE_IN      2'h0
`define TAPC_ROLE_OUT     2'h1
`define TAPC_ROLE_ALT1    2'h2
`define TAPC_ROLE_ALT2    2'h3

// axi responses
`define TAPC_RESP_OKAY    2'h0
`define TAPC_RESP_SLVERR  2'h2

`endif

// ---- logic/tapc_pin_cell.v ----
// one auxiliary pin: role mux, output enable and level sample
// assumes pin inputs are synchronous to clock
`timescale 1ns/10ps
`default_nettype none
`include "tapc_defines.vh"

module tapc_pin_cell (
	input  wire       clock,      // system clock
	input  wire       rst_n,      // sync reset, active low
	input  wire [1:0] sel,        // role code for this pin
	input  wire       prog_val,   // programmed output level
	input  wire       alt1_oe,    // drive enable for code 10
	input  wire       alt1_out,   // drive level for code 10
	input  wire       alt2_oe,    // drive enable for code 11
	input  wire       alt2_out,   // drive level for code 11
	input  wire       pin_in,     // level seen on the pin
	output reg        pin_out,    // level to drive
	output reg        pin_oe,     // high while driving
	output reg        level_r     // sampled pin level
);

	// role mux; a special role that is reserved passes oe low
	always @* begin
		pin_out = 1'b0;
		pin_oe  = 1'b0;
		case (sel)
			`TAPC_ROLE_IN: begin
				pin_oe = 1'b0;
			end
			`TAPC_ROLE_OUT: begin
				pin_out = prog_val;
				pin_oe  = 1'b1;
			end
			`TAPC_ROLE_ALT1: begin
				pin_out = alt1_out;
				pin_oe  = alt1_oe;
			end
			default: begin
				pin_out = alt2_out;
				pin_oe  = alt2_oe;
			end
		endcase
	end

	// level sample for the status read-back
	always @(posedge clock) begin
		if (!rst_n)
			level_r <= 1'b0;
		else
			level_r <= pin_in;
	end

endmodule // tapc_pin_cell

`default_nettype wire

// ---- logic/tapc_aux_pin_config.v ----
// top of the auxiliary pin configuration block
// holds the axi4-lite register slave and the role logic for pins a..e
// assumes all pin and core inputs are synchronous to clock
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "tapc_defines.vh"

module tapc_aux_pin_config (
	input  wire        clock,                 // 50 MHz system clock
	input  wire        rst_n,                 // sync reset, active low
	// axi4-lite write address
	input  wire [15:0] s_axi_awaddr,          // write byte address
	input  wire        s_axi_awvalid,         // write address valid
	output wire        s_axi_awready,         // write address ready
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,           // write data
	input  wire [3:0]  s_axi_wstrb,           // byte lane strobes
	input  wire        s_axi_wvalid,          // write data valid
	output wire        s_axi_wready,          // write data ready
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,           // write response
	output reg         s_axi_bvalid,          // write response valid
	input  wire        s_axi_bready,          // write response ready
	// axi4-lite read address
	input  wire [15:0] s_axi_araddr,          // read byte address
	input  wire        s_axi_arvalid,         // read address valid
	output wire        s_axi_arready,         // read address ready
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,           // read data
	output reg  [1:0]  s_axi_rresp,           // read response
	output reg         s_axi_rvalid,          // read data valid
	input  wire        s_axi_rready,          // read data ready
	// tdm clock role from the clocking block
	input  wire        clk_master_active,     // device drives tdm clocks
	// core side of the special roles
	output reg         clock_failure_flag,    // failure input level
	output reg         network_ref_clock_in,  // network clock from pin b
	output reg         msg_chan_rx_data,      // rx data from pin b
	input  wire        msg_chan_clock,        // message channel clock
	input  wire        timestamp_data,        // time stamp data bit
	input  wire        timestamp_valid,       // time stamp bit valid
	// auxiliary pins, three signals each
	input  wire        aux_pin_a_in,          // pin a level
	output wire        aux_pin_a_out,         // pin a drive level
	output wire        aux_pin_a_oe,          // pin a drive enable
	input  wire        aux_pin_b_in,          // pin b level
	output wire        aux_pin_b_out,         // pin b drive level
	output wire        aux_pin_b_oe,          // pin b drive enable
	input  wire        aux_pin_c_in,          // pin c level
	output wire        aux_pin_c_out,         // pin c drive level
	output wire        aux_pin_c_oe,          // pin c drive enable
	input  wire        aux_pin_d_in,          // pin d level
	output wire        aux_pin_d_out,         // pin d drive level
	output wire        aux_pin_d_oe,          // pin d drive enable
	input  wire        aux_pin_e_in,          // pin e level
	output wire        aux_pin_e_out,         // pin e drive level
	output wire        aux_pin_e_oe           // pin e drive enable
);

	////////////////////////////////////////////////////////////////////
	// configuration register and field views

	reg  [15:0] aux_pin_config_r;   // configuration word
	reg  [15:0] aux_pin_config_nxt; // next configuration word
	wire [1:0]  pin_a_role_sel;     // role of pin a
	wire [1:0]  pin_b_role_sel;     // role of pin b
	wire [1:0]  pin_c_role_sel;     // role of pin c
	wire [1:0]  pin_d_role_sel;     // role of pin d
	wire [1:0]  pin_e_role_sel;     // role of pin e
	wire [4:0]  pin_prog_val;       // programmed levels a..e
	wire [4:0]  pin_level;          // sampled levels a..e

	// field slices of the stored word
	assign pin_a_role_sel = aux_pin_config_r[`TAPC_SEL_A_LSB +: 2];
	assign pin_b_role_sel = aux_pin_config_r[`TAPC_SEL_B_LSB +: 2];
	assign pin_c_role_sel = aux_pin_config_r[`TAPC_SEL_C_LSB +: 2];
	assign pin_d_role_sel = aux_pin_config_r[`TAPC_SEL_D_LSB +: 2];
	assign pin_e_role_sel = aux_pin_config_r[`TAPC_SEL_E_LSB +: 2];
	assign pin_prog_val   = aux_pin_config_r[`TAPC_VAL_LSB +: `TAPC_NPINS];

	////////////////////////////////////////////////////////////////////
	// axi4-lite write path

	reg         aw_held_r;   // write address captured
	reg  [15:0] aw_addr_r;   // captured write address
	reg         w_held_r;    // write data captured
	reg  [31:0] w_data_r;    // captured write data
	reg  [3:0]  w_strb_r;    // captured strobes
	wire        aw_take;     // address handshake this edge
	wire        w_take;      // data handshake this edge
	wire        wr_fire;     // both halves present, no response pending
	wire        wr_hit_cfg;  // write targets the config word

	// ready while the half is empty and no response waits
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take  = s_axi_wvalid && s_axi_wready;
	assign wr_fire = aw_held_r && w_held_r;
	assign wr_hit_cfg = (aw_addr_r == `TAPC_CFG_ADDR);

	// capture each half in whatever order it arrives
	always @(posedge clock) begin
		if (!rst_n) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 16'h0000;
			w_held_r  <= 1'b0;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_r <= 1'b0;
			end
			if (w_take) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_r <= 1'b0;
			end
		end
	end

	// response one edge after both halves are held
	always @(posedge clock) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `TAPC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			// status word is read only, so a write to it is refused too
			s_axi_bresp  <= wr_hit_cfg ? `TAPC_RESP_OKAY : `TAPC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// byte-lane merge into the 16-bit word; upper lanes have no storage
	always @* begin
		aux_pin_config_nxt = aux_pin_config_r;
		if (wr_fire && wr_hit_cfg) begin
			if (w_strb_r[0])
				aux_pin_config_nxt[7:0] = w_data_r[7:0];
			if (w_strb_r[1])
				aux_pin_config_nxt[15:8] = w_data_r[15:8];
		end
	end

	// bit 10 is stored as written; software keeps it zero
	always @(posedge clock) begin
		if (!rst_n)
			aux_pin_config_r <= `TAPC_CFG_RST;
		else
			aux_pin_config_r <= aux_pin_config_nxt;
	end

	////////////////////////////////////////////////////////////////////
	// axi4-lite read path

	wire [15:0] stat_word;  // pin level read-back word
	wire        ar_take;    // read address handshake

	// pin levels sit in bits 15:11, the rest reads zero
	assign stat_word = {pin_level, 11'h000};

	// one read in flight; a new address waits until the data is taken
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_take = s_axi_arvalid && s_axi_arready;

	reg  [15:0] rd_word_nxt;  // word picked by the read address
	reg  [1:0]  rd_resp_nxt;  // response for that address

	// read address decode; unmapped addresses read zero with an error
	always @* begin
		rd_word_nxt = 16'h0000;
		rd_resp_nxt = `TAPC_RESP_SLVERR;
		case (s_axi_araddr)
			`TAPC_CFG_ADDR: begin
				rd_word_nxt = aux_pin_config_r;
				rd_resp_nxt = `TAPC_RESP_OKAY;
			end
			`TAPC_STAT_ADDR: begin
				rd_word_nxt = stat_word;
				rd_resp_nxt = `TAPC_RESP_OKAY;
			end
			default: begin
				rd_word_nxt = 16'h0000;
				rd_resp_nxt = `TAPC_RESP_SLVERR;
			end
		endcase
	end

	// data one edge after the address is taken
	always @(posedge clock) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `TAPC_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {16'h0000, rd_word_nxt};
			s_axi_rresp  <= rd_resp_nxt;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// special-role drive terms

	wire a_fail_out;   // pin a drive level in failure role
	wire a_fail_oe;    // pin a drive enable in failure role
	wire b_mc_tx;      // transmit bit for the channel line
	wire b_mc_oe;      // open-drain pull on pin b

	// active master pulls the failure line low; else it listens
	// takeover by an alternate is decided outside and shows on clk_master_active
	assign a_fail_out = 1'b0;
	assign a_fail_oe  = clk_master_active;

	// tx bit only counts while pin c is the tx input; otherwise idle high
	assign b_mc_tx = (pin_c_role_sel == `TAPC_ROLE_ALT1) ? aux_pin_c_in : 1'b1;
	// channel line is open drain: pull low on a zero, release on a one
	assign b_mc_oe = !b_mc_tx;

	////////////////////////////////////////////////////////////////////
	// pin cells

	// pin a: code 10 reserved, so alt1 never drives
	tapc_pin_cell u_pin_a (
		.clock    (clock),
		.rst_n    (rst_n),
		.sel      (pin_a_role_sel),
		.prog_val (pin_prog_val[0]),
		.alt1_oe  (1'b0),
		.alt1_out (1'b0),
		.alt2_oe  (a_fail_oe),
		.alt2_out (a_fail_out),
		.pin_in   (aux_pin_a_in),
		.pin_out  (aux_pin_a_out),
		.pin_oe   (aux_pin_a_oe),
		.level_r  (pin_level[0])
	);

	// pin b: channel line, or network clock input that never drives
	tapc_pin_cell u_pin_b (
		.clock    (clock),
		.rst_n    (rst_n),
		.sel      (pin_b_role_sel),
		.prog_val (pin_prog_val[1]),
		.alt1_oe  (b_mc_oe),
		.alt1_out (1'b0),
		.alt2_oe  (1'b0),
		.alt2_out (1'b0),
		.pin_in   (aux_pin_b_in),
		.pin_out  (aux_pin_b_out),
		.pin_oe   (aux_pin_b_oe),
		.level_r  (pin_level[1])
	);

	// pin c: tx data input, or time stamp valid output
	tapc_pin_cell u_pin_c (
		.clock    (clock),
		.rst_n    (rst_n),
		.sel      (pin_c_role_sel),
		.prog_val (pin_prog_val[2]),
		.alt1_oe  (1'b0),
		.alt1_out (1'b0),
		.alt2_oe  (1'b1),
		.alt2_out (timestamp_valid),
		.pin_in   (aux_pin_c_in),
		.pin_out  (aux_pin_c_out),
		.pin_oe   (aux_pin_c_oe),
		.level_r  (pin_level[2])
	);

	// pin d: received channel data, or time stamp data
	tapc_pin_cell u_pin_d (
		.clock    (clock),
		.rst_n    (rst_n),
		.sel      (pin_d_role_sel),
		.prog_val (pin_prog_val[3]),
		.alt1_oe  (1'b1),
		.alt1_out (msg_chan_rx_data),
		.alt2_oe  (1'b1),
		.alt2_out (timestamp_data),
		.pin_in   (aux_pin_d_in),
		.pin_out  (aux_pin_d_out),
		.pin_oe   (aux_pin_d_oe),
		.level_r  (pin_level[3])
	);

	// pin e: channel clock out; code 11 reserved and undriven
	tapc_pin_cell u_pin_e (
		.clock    (clock),
		.rst_n    (rst_n),
		.sel      (pin_e_role_sel),
		.prog_val (pin_prog_val[4]),
		.alt1_oe  (1'b1),
		.alt1_out (msg_chan_clock),
		.alt2_oe  (1'b0),
		.alt2_out (1'b0),
		.pin_in   (aux_pin_e_in),
		.pin_out  (aux_pin_e_out),
		.pin_oe   (aux_pin_e_oe),
		.level_r  (pin_level[4])
	);

	////////////////////////////////////////////////////////////////////
	// core-side inputs taken from the pins

	// failure input heard only while not the active master;
	// idle high keeps the failure line quiet when the role is off
	always @(posedge clock) begin
		if (!rst_n)
			clock_failure_flag <= 1'b1;
		else if (pin_a_role_sel == `TAPC_ROLE_ALT2 && !clk_master_active)
			clock_failure_flag <= aux_pin_a_in;
		else
			clock_failure_flag <= 1'b1;
	end

	// network clock sits low while pin b has another role
	always @(posedge clock) begin
		if (!rst_n)
			network_ref_clock_in <= 1'b0;
		else if (pin_b_role_sel == `TAPC_ROLE_ALT2)
			network_ref_clock_in <= aux_pin_b_in;
		else
			network_ref_clock_in <= 1'b0;
	end

	// received data idles high, the quiet level of the channel
	always @(posedge clock) begin
		if (!rst_n)
			msg_chan_rx_data <= 1'b1;
		else if (pin_b_role_sel == `TAPC_ROLE_ALT1)
			msg_chan_rx_data <= aux_pin_b_in;
		else
			msg_chan_rx_data <= 1'b1;
	end

endmodule // tapc_aux_pin_config

`default_nettype wire

// ---- bench/tapc_aux_pin_config_checker.sv ----
// assertion checker for the auxiliary pin block
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module tapc_aux_pin_config_checker (
	input wire logic        clock,                // clock
	input wire logic        rst_n,                // reset
	input wire logic        s_axi_awvalid,        // aw valid
	input wire logic        s_axi_awready,        // aw ready
	input wire logic        s_axi_wvalid,         // w valid
	input wire logic        s_axi_wready,         // w ready
	input wire logic        s_axi_bvalid,         // b valid
	input wire logic [15:0] s_axi_araddr,         // read addr
	input wire logic        s_axi_arvalid,        // ar valid
	input wire logic        s_axi_arready,        // ar ready
	input wire logic [31:0] s_axi_rdata,          // read data
	input wire logic [1:0]  s_axi_rresp,          // read resp
	input wire logic        s_axi_rvalid,         // r valid
	input wire logic        clk_master_active,    // master
	input wire logic        clock_failure_flag,   // fail flag
	input wire logic        network_ref_clock_in, // net clock
	input wire logic        msg_chan_rx_data,     // rx data
	input wire logic        aux_pin_a_in,         // pin a
	input wire logic        aux_pin_b_in,         // pin b
	input wire logic        aux_pin_a_oe,         // a enable
	input wire logic        aux_pin_b_oe,         // b enable
	input wire logic        aux_pin_c_oe,         // c enable
	input wire logic        aux_pin_d_oe,         // d enable
	input wire logic        aux_pin_e_oe          // e enable
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	// reset leaves every pin released and the bus idle
	property p_reset_idle;
		$rose(rst_n) |-> !(aux_pin_a_oe | aux_pin_b_oe | aux_pin_c_oe | aux_pin_d_oe
			| aux_pin_e_oe) && !s_axi_bvalid && !s_axi_rvalid && clock_failure_flag;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("busy after reset");
	// write answer two edges after both halves are taken
	property p_wr_latency;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_latency: assert property (p_wr_latency) else $error("late write answer");
	// a pending answer blocks new writes
	property p_b_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_block: assert property (p_b_block) else $error("write taken while answering");
	property p_rd_latency;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("late read answer");
	// unmapped reads answer slave error and zero
	property p_rd_unmapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr != 16'h6004 && s_axi_araddr != 16'h6008
			|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("bad unmapped read");
	// status word holds only the five pin levels
	property p_rd_status;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 16'h6008
			|=> s_axi_rdata[10:0] == 11'h0 && s_axi_rdata[31:16] == 16'h0;
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("stray status bits");
	// flag low only from a low pin while not master
	property p_fail_flag;
		!clock_failure_flag |-> !$past(aux_pin_a_in) && !$past(clk_master_active);
	endproperty
	a_fail_flag: assert property (p_fail_flag) else $error("false failure flag");
	property p_net_clk;
		network_ref_clock_in |-> $past(aux_pin_b_in);
	endproperty
	a_net_clk: assert property (p_net_clk) else $error("net clock not from pin b");
	property p_rx_data;
		!msg_chan_rx_data |-> !$past(aux_pin_b_in);
	endproperty
	a_rx_data: assert property (p_rx_data) else $error("rx data not from pin b");
endmodule // tapc_aux_pin_config_checker
bind tapc_aux_pin_config tapc_aux_pin_config_checker chk_u (.*);
`default_nettype wire

// ---- bench/tapc_pin_peer.sv ----
// far side of the five pins: peers and pull-ups
// assumes the block's enables are high while it drives
`timescale 1ns/10ps
`default_nettype none
module tapc_pin_peer (
	input  wire logic [4:0] oe,       // block enables e..a
	input  wire logic [4:0] drv,      // block levels
	input  wire logic [4:0] peer_en,  // peer enables
	input  wire logic [4:0] peer_val, // peer levels
	output logic      [4:0] lvl       // wire levels
);
	// wired-and with pull-ups so a released line goes high, never keeps old data
	assign lvl = (~oe | drv) & (~peer_en | peer_val);
endmodule // tapc_pin_peer
`default_nettype wire

// ---- bench/tapc_aux_pin_config_tb_top.sv ----
// testbench for the auxiliary pin block
// assumes the peer model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tapc_aux_pin_config_tb_top;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, clk_master_active = 1'b0;
	logic        msg_chan_clock = 1'b0, timestamp_data = 1'b0, timestamp_valid = 1'b0;
	logic [4:0]  peer_en = 5'h0, peer_val = 5'h0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire         clock_failure_flag, network_ref_clock_in, msg_chan_rx_data;
	wire         aux_pin_a_in, aux_pin_b_in, aux_pin_c_in, aux_pin_d_in, aux_pin_e_in;
	wire         aux_pin_a_out, aux_pin_b_out, aux_pin_c_out, aux_pin_d_out, aux_pin_e_out;
	wire         aux_pin_a_oe, aux_pin_b_oe, aux_pin_c_oe, aux_pin_d_oe, aux_pin_e_oe;
	wire [4:0]   oe_v, out_v, lvl;
	wire [12:0]  pv;
	int          mismatches = 0;
	int          checks_done = 0;
	////////////////////////////////////////////////////////////////
	// pin vectors, e..a, levels masked by enables
	assign oe_v = {aux_pin_e_oe, aux_pin_d_oe, aux_pin_c_oe, aux_pin_b_oe, aux_pin_a_oe};
	assign out_v = {aux_pin_e_out, aux_pin_d_out, aux_pin_c_out, aux_pin_b_out, aux_pin_a_out};
	assign {aux_pin_e_in, aux_pin_d_in, aux_pin_c_in, aux_pin_b_in, aux_pin_a_in} = lvl;
	assign pv = {oe_v, out_v & oe_v, network_ref_clock_in, msg_chan_rx_data, clock_failure_flag};
	tapc_aux_pin_config dut_u (.*);
	tapc_pin_peer peer_u (.oe(oe_v), .drv(out_v), .peer_en(peer_en), .peer_val(peer_val),
		.lvl(lvl));
	// 50 MHz clock
	always #10 clock = ~clock;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	// each ready and the answer are seen at a rising edge; only the watchdog ends a wait
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] st,
		input logic [1:0] er);
		logic hs;
		logic [1:0] r;
		hs = 1'b0;
		r = 2'h0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!hs) begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				hs = 1'b1;
				r = s_axi_bresp;
			end
		end
		s_axi_bready <= 1'b0;
		chk({31'h0, hs}, 32'h1);
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic hs;
		logic [31:0] d;
		logic [1:0] r;
		hs = 1'b0;
		d = 32'h0;
		r = 2'h0;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!hs) begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				hs = 1'b1;
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
		end
		s_axi_rready <= 1'b0;
		chk({31'h0, hs}, 32'h1);
		chk(d, ed);
		chk({30'h0, r}, {30'h0, er});
	endtask
	// registered core outputs need a few edges to settle
	task automatic pins(input logic [12:0] e);
		repeat (3) @(negedge clock);
		chk({19'h0, pv}, {19'h0, e});
	endtask
	task automatic do_reset();
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_gpio();
		wr(16'h6004, 32'h0000A955, 4'h3, 2'h0);
		pins(13'h1FAB);
		rd(16'h6004, 32'h0000A955, 2'h0);
		rd(16'h6008, 32'h0000A800, 2'h0);
		wr(16'h6004, 32'h0000F800, 4'h3, 2'h0);
		pins(13'h0003);
		@(posedge clock);
		peer_en <= 5'h1F;
		rd(16'h6008, 32'h00000000, 2'h0);
		@(posedge clock);
		peer_en <= 5'h00;
		rd(16'h6008, 32'h0000F800, 2'h0);
		wr(16'h6004, 32'h00000155, 4'h1, 2'h0);
		pins(13'h0F7B);
		rd(16'h6004, 32'h0000F855, 2'h0);
		$display("test gpio done");
	endtask
	task automatic t_msg_chan();
		@(posedge clock);
		clk_master_active <= 1'b1;
		peer_en <= 5'h04;
		wr(16'h6004, 32'h000002AB, 4'h3, 2'h0);
		pins(13'h1B01);
		@(posedge clock);
		peer_val <= 5'h04;
		msg_chan_clock <= 1'b1;
		pins(13'h19C3);
		@(posedge clock);
		clk_master_active <= 1'b0;
		peer_en <= 5'h05;
		pins(13'h18C2);
		$display("test message channel done");
	endtask
	task automatic t_stamp();
		@(posedge clock);
		peer_en <= 5'h03;
		peer_val <= 5'h02;
		timestamp_valid <= 1'b1;
		wr(16'h6004, 32'h000003FE, 4'h3, 2'h0);
		pins(13'h0C27);
		@(posedge clock);
		peer_val <= 5'h00;
		timestamp_valid <= 1'b0;
		timestamp_data <= 1'b1;
		pins(13'h0C43);
		$display("test time stamp done");
	endtask
	task automatic t_bus();
		wr(16'h6000, 32'h0000FBFF, 4'h3, 2'h2);
		wr(16'h6008, 32'h0000FBFF, 4'h3, 2'h2);
		rd(16'h6010, 32'h0, 2'h2);
		rd(16'h6004, 32'h000003FE, 2'h0);
		do_reset();
		rd(16'h6004, 32'h0, 2'h0);
		pins(13'h0003);
		$display("test bus and reset done");
	endtask
	////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		rd(16'h6004, 32'h0, 2'h0);
		pins(13'h0003);
		t_gpio();
		t_msg_chan();
		t_stamp();
		t_bus();
		conclude();
	end
	// watchdog, far beyond the fewer than two hundred cycles needed
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		conclude();
	end
endmodule // tapc_aux_pin_config_tb_top
`default_nettype wire
